// [logic/ccsr_top.sv]
// can control and status registers with classic wishbone slave
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/100ps
module ccsr_top
  import ccsr_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // protocol engine side
  input  wire ccsr_evt_t   evt,
  input  wire logic [8:0]  tx_error_counter,
  input  wire logic [8:0]  rx_error_counter,
  output ccsr_gate_t       gate,
  output logic [23:0]      bit_timing,
  output logic             listen_only,
  // interrupt line to the system interrupt controller
  output logic             can_irq
);

  ccsr_wb_st_t wb_st;         // bus answer state
  logic [7:0]  can_control;   // control register
  logic        rx_done_flag;  // status bit 4
  logic        tx_done_flag;  // status bit 3
  ccsr_lfc_t   last_fault_code; // status bits 2..0
  logic        bus_off_flag;
  logic        error_passive_flag;
  logic        warning_level_flag;
  logic        flags_changed;  // pulse from decode
  logic [31:0] system_time;    // free-running system time
  logic [31:0] rx_delay_timer; // microsecond count
  logic [7:0]  us_div;         // prescaler to 1 us
  logic        err_irq_pend;   // pending error-state request
  logic        stat_irq_pend;  // pending status-change request
  logic [7:0]  status_view;    // assembled status byte
  logic        req;            // new request this cycle
  logic        wr;             // write taking effect
  logic        rd;             // read taking effect
  logic        mapped;         // address decodes
  logic [7:0]  idx;            // register index

  // register index from byte address
  function automatic logic [7:0] word_index(input logic [9:0] adr);
    word_index = adr[CCSR_IDX_LSB +: 8];
  endfunction

  // is this index one of ours
  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == CCSR_IDX_CONTROL) || (i == CCSR_IDX_STATUS) ||
                (i == CCSR_IDX_TIMING)  || (i == CCSR_IDX_SYSTIME) ||
                (i == CCSR_IDX_RX_DELAY_TIMER_ENABLE)   || (i == CCSR_IDX_ERRCNT) ||
                (i == CCSR_IDX_IRQ);
  endfunction

  // decoded bus request; a write or read acts in the request's first cycle
  always_comb
  begin
    idx    = word_index(wb_adr_i);
    mapped = is_mapped(idx);
    req    = wb_cyc_i && wb_stb_i && (wb_st == WB_IDLE);
    wr     = req && wb_we_i && mapped && wb_sel_i[0];
    rd     = req && !wb_we_i && mapped;
  end

  // error state flags from counters
  ccsr_err_state u_err_state
  (
    .core_clk           (core_clk),
    .rst_b              (rst_b),
    .tx_error_counter   (tx_error_counter),
    .rx_error_counter   (rx_error_counter),
    .bus_off_flag       (bus_off_flag),
    .error_passive_flag (error_passive_flag),
    .warning_level_flag (warning_level_flag),
    .flags_changed      (flags_changed)
  );

  // answer one cycle after the request, then drop for a cycle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wb_st    <= WB_IDLE;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end
    else
    begin
      case (wb_st)
        WB_IDLE:
        begin
          wb_ack_o <= req && mapped;
          wb_err_o <= req && !mapped;  // unmapped answers with err
          if (req)
            wb_st <= WB_ACK;
        end
        WB_ACK:
        begin
          wb_ack_o <= 1'b0;
          wb_err_o <= 1'b0;
          wb_st    <= WB_IDLE;
        end
        default:
        begin
          wb_ack_o <= 1'b0;
          wb_err_o <= 1'b0;
          wb_st    <= WB_IDLE;
        end
      endcase
    end
  end

  // control register; setup hold comes out of reset set
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      can_control <= CTL_RESET;
    else if (wr && (idx == CCSR_IDX_CONTROL))
      can_control <= wb_dat_i[7:0];
  end

  // bit timing register; locked unless unlock bit set
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      bit_timing <= TIMING_RESET;
    else if (wr && (idx == CCSR_IDX_TIMING) && can_control[CTL_UNLOCK])
      bit_timing <= wb_dat_i[23:0] & TIMING_MASK;
  end

  // done flags: hardware set wins over a software write
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_done_flag <= 1'b0;
      tx_done_flag <= 1'b0;
    end
    else
    begin
      if (evt.rx_ok)
        rx_done_flag <= 1'b1;
      else if (wr && (idx == CCSR_IDX_STATUS))
        rx_done_flag <= wb_dat_i[ST_RX_DONE];
      // engine reports tx_ok only for acked error-free frames
      if (evt.tx_ok)
        tx_done_flag <= 1'b1;
      else if (wr && (idx == CCSR_IDX_STATUS))
        tx_done_flag <= wb_dat_i[ST_TX_DONE];
    end
  end

  // last fault code; hardware update wins over software
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      last_fault_code <= LFC_UNUSED;
    else if (evt.bus_err && (evt.err_code != LFC_UNUSED))
      last_fault_code <= evt.err_code;
    else if (evt.rx_ok || evt.tx_ok)
      last_fault_code <= LFC_NONE;
    else if (wr && (idx == CCSR_IDX_STATUS))
      last_fault_code <= ccsr_lfc_t'(wb_dat_i[2:0]);
  end

  // 1 us prescaler and receive delay timer
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      us_div         <= 8'h00;
      rx_delay_timer <= 32'h0000_0000;
    end
    else if (!can_control[CTL_RX_DELAY_TIMER_ENABLE])
    begin
      // disabled timer restarts from zero when enabled again
      us_div         <= 8'h00;
      rx_delay_timer <= 32'h0000_0000;
    end
    else if (us_div == RX_DELAY_TIMER_ENABLE_LAST)
    begin
      us_div         <= 8'h00;
      rx_delay_timer <= rx_delay_timer + 32'h0000_0001;
    end
    else
      us_div <= us_div + 8'h01;
  end

  // free-running system time; holds while disabled
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      system_time <= 32'h0000_0000;
    else if (can_control[CTL_SYSTIME])
      system_time <= system_time + 32'h0000_0001;
  end

  // pending requests; a new event wins over a clear by read
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      err_irq_pend  <= 1'b0;
      stat_irq_pend <= 1'b0;
    end
    else
    begin
      if (flags_changed && can_control[CTL_ERR_IE])
        err_irq_pend <= 1'b1;
      else if (rd && (idx == CCSR_IDX_STATUS))
        err_irq_pend <= 1'b0;
      if ((evt.rx_ok || evt.tx_ok || evt.bus_err) &&
          can_control[CTL_STAT_IE])
        stat_irq_pend <= 1'b1;
      else if (rd && (idx == CCSR_IDX_STATUS))
        stat_irq_pend <= 1'b0;
    end
  end

  // interrupt line; only the global enable gates it
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      can_irq <= 1'b0;
    else
      can_irq <= can_control[CTL_GLOB_IE] &&
                 (err_irq_pend || stat_irq_pend);
  end

  // gating toward the protocol engine
  always_comb
  begin
    listen_only         = can_control[CTL_LISTEN];
    gate.rx_allow       = !can_control[CTL_HOLD];
    gate.tx_allow       = !can_control[CTL_HOLD] &&
                          !can_control[CTL_LISTEN];
    gate.ack_allow      = !can_control[CTL_HOLD] &&
                          !can_control[CTL_LISTEN];
    gate.obj_unlock     = can_control[CTL_HOLD];
    status_view         = {bus_off_flag, error_passive_flag,
                           warning_level_flag, rx_done_flag,
                           tx_done_flag, last_fault_code};
  end

  // read data registered with the answer
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      wb_dat_o <= 32'h0000_0000;
    else if (rd)
    begin
      case (idx)
        CCSR_IDX_CONTROL: wb_dat_o <= {24'h00_0000, can_control};
        CCSR_IDX_STATUS:  wb_dat_o <= {24'h00_0000, status_view};
        CCSR_IDX_TIMING:  wb_dat_o <= {8'h00, bit_timing};
        CCSR_IDX_SYSTIME: wb_dat_o <= system_time;
        CCSR_IDX_RX_DELAY_TIMER_ENABLE:   wb_dat_o <= rx_delay_timer;
        CCSR_IDX_ERRCNT:  wb_dat_o <= {7'h00, rx_error_counter,
                                       7'h00, tx_error_counter};
        CCSR_IDX_IRQ:     wb_dat_o <= {29'h0000_0000, can_irq,
                                       err_irq_pend, stat_irq_pend};
        default:          wb_dat_o <= 32'h0000_0000;
      endcase
    end
    else if (req)
      wb_dat_o <= 32'h0000_0000;
  end

endmodule

// [logic/ccsr_pkg.sv]
// package of constants and carrier types for the can control/status block
package ccsr_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] CCSR_IDX_CONTROL = 8'h00;
  localparam logic [7:0] CCSR_IDX_STATUS  = 8'h01;
  localparam logic [7:0] CCSR_IDX_TIMING  = 8'h05;
  // offsets of our own for counters, error inputs view and interrupt view
  localparam logic [7:0] CCSR_IDX_SYSTIME = 8'h40;
  localparam logic [7:0] CCSR_IDX_RX_DELAY_TIMER_ENABLE   = 8'h41;
  localparam logic [7:0] CCSR_IDX_ERRCNT  = 8'h42;
  localparam logic [7:0] CCSR_IDX_IRQ     = 8'h43;
  localparam int unsigned CCSR_IDX_LSB    = 2;

  // control bit positions
  localparam int unsigned CTL_LISTEN   = 7;
  localparam int unsigned CTL_UNLOCK   = 6;
  localparam int unsigned CTL_RX_DELAY_TIMER_ENABLE    = 5;
  localparam int unsigned CTL_SYSTIME  = 4;
  localparam int unsigned CTL_ERR_IE   = 3;
  localparam int unsigned CTL_STAT_IE  = 2;
  localparam int unsigned CTL_GLOB_IE  = 1;
  localparam int unsigned CTL_HOLD     = 0;
  localparam logic [7:0]  CTL_RESET    = 8'h01;

  // status bit positions
  localparam int unsigned ST_BUS_OFF   = 7;
  localparam int unsigned ST_PASSIVE   = 6;
  localparam int unsigned ST_WARNING   = 5;
  localparam int unsigned ST_RX_DONE   = 4;
  localparam int unsigned ST_TX_DONE   = 3;
  localparam logic [7:0]  ST_RESET     = 8'h87;

  // error counter limits
  localparam logic [8:0] ERR_BUS_OFF   = 9'h100;
  localparam logic [8:0] ERR_PASSIVE   = 9'h080;
  localparam logic [8:0] ERR_PASS_TOP  = 9'h0ff;
  localparam logic [8:0] ERR_WARNING   = 9'h060;

  // bit timing register reset value and writable bits
  localparam logic [23:0] TIMING_RESET = 24'h12_0000;
  localparam logic [23:0] TIMING_MASK  = 24'hff_ffc0;

  // receive delay timer tick: 1 us at 125 MHz
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned RX_DELAY_TIMER_ENABLE_TICK_US = 1;
  localparam int unsigned RX_DELAY_TIMER_ENABLE_CYCLES = RX_DELAY_TIMER_ENABLE_TICK_US * CLK_MHZ;
  localparam logic [7:0]  RX_DELAY_TIMER_ENABLE_LAST   = 8'(RX_DELAY_TIMER_ENABLE_CYCLES - 1);

  // last fault codes
  typedef enum logic [2:0]
  {
    LFC_NONE    = 3'h0,
    LFC_STUFF   = 3'h1,
    LFC_FORM    = 3'h2,
    LFC_ACK     = 3'h3,
    LFC_BIT_REC = 3'h4,
    LFC_BIT_DOM = 3'h5,
    LFC_CRC     = 3'h6,
    LFC_UNUSED  = 3'h7
  } ccsr_lfc_t;

  // events reported by the protocol engine
  typedef struct packed
  {
    logic      rx_ok;
    logic      tx_ok;
    logic      bus_err;
    ccsr_lfc_t err_code;
  } ccsr_evt_t;

  // gating handed to the protocol engine
  typedef struct packed
  {
    logic tx_allow;
    logic ack_allow;
    logic rx_allow;
    logic obj_unlock;
  } ccsr_gate_t;

  // classic wishbone slave bus state
  typedef enum logic [1:0]
  {
    WB_IDLE = 2'b00,
    WB_ACK  = 2'b01
  } ccsr_wb_st_t;

endpackage

// [logic/ccsr_err_state.sv]
// error state flag decode from the two error counters
`timescale 1ns/100ps
module ccsr_err_state
  import ccsr_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // counters from the protocol engine
  input  wire logic [8:0] tx_error_counter,
  input  wire logic [8:0] rx_error_counter,
  // registered flags and change pulse
  output logic            bus_off_flag,
  output logic            error_passive_flag,
  output logic            warning_level_flag,
  output logic            flags_changed
);

  logic next_bus_off_flag;   // decoded bus-off
  logic next_error_passive_flag;   // decoded error passive
  logic next_warning_level_flag;   // decoded warning

  // combinational decode of the counter thresholds
  always_comb
  begin
    next_bus_off_flag = tx_error_counter >= ERR_BUS_OFF;
    // tx side passive only below the top value, as documented
    next_error_passive_flag = (rx_error_counter >= ERR_PASSIVE) ||
                ((tx_error_counter >= ERR_PASSIVE) &&
                 (tx_error_counter < ERR_PASS_TOP));
    next_warning_level_flag = (tx_error_counter >= ERR_WARNING) ||
                (rx_error_counter >= ERR_WARNING);
  end

  // flags register; bus-off resets to one
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus_off_flag       <= 1'b1;
      error_passive_flag <= 1'b0;
      warning_level_flag <= 1'b0;
    end
    else
    begin
      bus_off_flag       <= next_bus_off_flag;
      error_passive_flag <= next_error_passive_flag;
      warning_level_flag <= next_warning_level_flag;
    end
  end

  // one-cycle pulse when any flag moves
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      flags_changed <= 1'b0;
    else
      flags_changed <= (next_bus_off_flag != bus_off_flag) ||
                       (next_error_passive_flag != error_passive_flag) ||
                       (next_warning_level_flag != warning_level_flag);
  end

endmodule

// [tb/ccsr_props.sv]
// checker of bus answer, gating, timing lock and error flags
`timescale 1ns/100ps
module ccsr_props
  import ccsr_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_b,
  // register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  // engine side
  input wire logic [8:0]  tx_error_counter,
  input wire logic [8:0]  rx_error_counter,
  input wire ccsr_gate_t  gate,
  input wire logic [23:0] bit_timing,
  input wire logic        listen_only,
  input wire logic        can_irq
);
  logic        unl;    // unlock bit as last written
  logic        gie;    // global enable as last written
  logic [17:0] cnt_d1; // counters one cycle back
  logic [17:0] cnt_d2; // counters two cycles back
  // flags are only judged once counters sat still long enough to decode
  wire calm = cnt_d1 == {tx_error_counter, rx_error_counter} &&
              cnt_d2 == cnt_d1;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // shadows follow the acked control write, one edge after the design
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      unl <= 1'b0;
      gie <= 1'b0;
    end
    else if (wb_ack_o && wb_we_i && wb_sel_i[0] &&
             wb_adr_i[9:2] == CCSR_IDX_CONTROL)
    begin
      unl <= wb_dat_i[CTL_UNLOCK];
      gie <= wb_dat_i[CTL_GLOB_IE];
    end

  // counter history for the calm window
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      cnt_d1 <= '0;
      cnt_d2 <= '0;
    end
    else
    begin
      cnt_d1 <= {tx_error_counter, rx_error_counter};
      cnt_d2 <= cnt_d1;
    end

  sequence s_rd;
    $rose(wb_stb_i) && wb_cyc_i && !wb_we_i &&
    wb_adr_i[9:2] == CCSR_IDX_STATUS && calm;
  endsequence

  property p_listen;
    listen_only |-> !gate.ack_allow && !gate.tx_allow;
  endproperty
  a_listen: assert property (p_listen) else $error("listen leak");
  property p_hold;
    gate.obj_unlock |-> !gate.tx_allow && !gate.rx_allow;
  endproperty
  a_hold: assert property (p_hold) else $error("hold leak");
  property p_answer;
    $rose(wb_stb_i) && wb_cyc_i |=> (wb_ack_o ^ wb_err_o) ##1 !wb_ack_o;
  endproperty
  a_answer: assert property (p_answer) else $error("bad bus answer");
  property p_lock;
    !unl |=> $stable(bit_timing);
  endproperty
  a_lock: assert property (p_lock) else $error("locked timing moved");
  property p_twrite;
    $rose(wb_stb_i) && wb_we_i && wb_sel_i[0] && unl &&
    wb_adr_i[9:2] == CCSR_IDX_TIMING |=>
    bit_timing == (wb_dat_i[23:0] & TIMING_MASK);
  endproperty
  a_twrite: assert property (p_twrite) else $error("timing lost");
  property p_bus_off_flag;
    s_rd |=> wb_dat_o[ST_BUS_OFF] ==
             ($past(tx_error_counter) >= ERR_BUS_OFF);
  endproperty
  a_bus_off_flag: assert property (p_bus_off_flag) else $error("bus off flag");
  property p_pass;
    s_rd |=> wb_dat_o[ST_PASSIVE] ==
      ($past(rx_error_counter) >= ERR_PASSIVE ||
       ($past(tx_error_counter) >= ERR_PASSIVE &&
        $past(tx_error_counter) < ERR_PASS_TOP));
  endproperty
  a_pass: assert property (p_pass) else $error("passive flag");
  property p_warn;
    s_rd |=> wb_dat_o[ST_WARNING] ==
      ($past(rx_error_counter) >= ERR_WARNING ||
       $past(tx_error_counter) >= ERR_WARNING);
  endproperty
  a_warn: assert property (p_warn) else $error("warning flag");
  property p_irq;
    !gie |-> !can_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not gated");
endmodule

bind ccsr_top ccsr_props u_props (.core_clk, .rst_b, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .wb_err_o, .tx_error_counter, .rx_error_counter, .gate,
  .bit_timing, .listen_only, .can_irq);

// [tb/ccsr_node_model.sv]
// far bus node: turns bench offers into engine event pulses
`timescale 1ns/100ps
module ccsr_node_model
  import ccsr_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // offer from the bench: 1 rx, 2 tx, 3 error
  input  wire logic [1:0] offer,
  input  wire ccsr_lfc_t  code,
  // engine side
  input  wire ccsr_gate_t gate,
  output ccsr_evt_t       evt
);
  // a frame only passes when the gate lets it onto the bus
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      evt <= '0;
    else
    begin
      evt.rx_ok    <= offer == 2'h1 && gate.rx_allow;
      evt.tx_ok    <= offer == 2'h2 && gate.tx_allow;
      evt.bus_err  <= offer == 2'h3 && gate.rx_allow;
      evt.err_code <= code;
    end
endmodule

// [tb/tb_top.sv]
// self-checking bench for the can control and status registers
`timescale 1ns/100ps
module tb_top
  import ccsr_pkg::*;
;
  localparam logic [9:0] A_CTL = {CCSR_IDX_CONTROL, 2'h0};
  localparam logic [9:0] A_ST  = {CCSR_IDX_STATUS, 2'h0};
  localparam logic [9:0] A_TIM = {CCSR_IDX_TIMING, 2'h0};
  localparam logic [9:0] A_SYS = {CCSR_IDX_SYSTIME, 2'h0};
  localparam logic [9:0] A_DLY = {CCSR_IDX_RX_DELAY_TIMER_ENABLE, 2'h0};
  localparam logic [9:0] A_CNT = {CCSR_IDX_ERRCNT, 2'h0};
  localparam logic [9:0] A_IRQ = {CCSR_IDX_IRQ, 2'h0};
  logic        core_clk = 1'b0;
  logic        rst_b    = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [9:0]  wb_adr_i = 10'h000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [3:0]  wsel     = 4'hf; // lanes for the next request
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [8:0]  tx_error_counter = 9'h000;
  logic [8:0]  rx_error_counter = 9'h000;
  logic [1:0]  offer = 2'h0;
  ccsr_lfc_t   code  = LFC_NONE;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        wb_err_o;
  logic        lerr;
  ccsr_evt_t   evt;
  ccsr_gate_t  gate;
  logic [23:0] bit_timing;
  logic        listen_only;
  logic        can_irq;
  int          checks    = 0;
  int          bad_count = 0;

  always #4 core_clk = ~core_clk;

  ccsr_top DUT (.core_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .wb_err_o, .evt, .tx_error_counter, .rx_error_counter, .gate,
    .bit_timing, .listen_only, .can_irq);
  ccsr_node_model node (.core_clk, .rst_b, .offer, .code, .gate, .evt);

  task automatic tally_and_finish();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle; request held until ack or err is sampled
  task automatic wb(input logic we, input logic [9:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <=
      {2'h3, we, a, wsel, d};
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    lerr = wb_err_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (n >= 20)
    begin
      bad_count++;
      tally_and_finish();
    end
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [9:0] a,
                     input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(nm, q, e);
  endtask
  // one-cycle offer from the far node, then let it settle
  task automatic send(input logic [1:0] k, input ccsr_lfc_t c);
    offer <= k;
    code <= c;
    @(posedge core_clk);
    offer <= 2'h0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic flag(input logic [8:0] t, r, input logic [2:0] e);
    logic [31:0] q;
    {tx_error_counter, rx_error_counter} <= {t, r};
    repeat (4) @(posedge core_clk);
    wb(1'b0, A_ST, 32'h0000_0000, q);
    chk("flags", {29'h0, q[7:5]}, {29'h0, e});
  endtask

  task automatic t_reset();
    rdc("ctl", A_CTL, 32'h0000_0001);
    rdc("st", A_ST, 32'h0000_0007);
    chk("gate", {28'h0, gate}, 32'h0000_0001);
    send(2'h1, LFC_NONE);
    rdc("st_hold", A_ST, 32'h0000_0007);
    rdc("unmap", 10'h3fc, 32'h0000_0000);
    chk("err", {31'h0, lerr}, 32'h1);
    $display("t_reset done");
  endtask
  task automatic t_timing();
    wr(A_TIM, 32'hffff_ffff);
    rdc("tim_lock", A_TIM, 32'h0012_0000);
    // a write without the low lane must leave control untouched
    wsel = 4'he;
    wr(A_CTL, 32'h0000_0041);
    wsel = 4'hf;
    rdc("sel_off", A_CTL, 32'h0000_0001);
    wr(A_CTL, 32'h0000_0041);
    wr(A_TIM, 32'hffff_ffff);
    rdc("tim_open", A_TIM, 32'h00ff_ffc0);
    wr(A_CTL, 32'h0000_0001);
    $display("t_timing done");
  endtask
  task automatic t_flags();
    flag(9'h060, 9'h000, 3'h1);
    flag(9'h000, 9'h05f, 3'h0);
    flag(9'h000, 9'h080, 3'h3);
    flag(9'h080, 9'h000, 3'h3);
    flag(9'h0ff, 9'h000, 3'h1);
    flag(9'h100, 9'h000, 3'h5);
    flag(9'h000, 9'h000, 3'h0);
    wr(A_ST, 32'h0000_00e7);
    rdc("st_ro", A_ST, 32'h0000_0007);
    $display("t_flags done");
  endtask
  task automatic t_events();
    wr(A_CTL, 32'h0000_0000);
    send(2'h1, LFC_NONE);
    rdc("rx", A_ST, 32'h0000_0010);
    send(2'h2, LFC_NONE);
    rdc("tx", A_ST, 32'h0000_0018);
    for (int c = 1; c < 7; c++)
    begin
      send(2'h3, ccsr_lfc_t'(c));
      rdc("lfc", A_ST, 32'h0000_0018 | c);
    end
    send(2'h1, LFC_NONE);
    rdc("lfc0", A_ST, 32'h0000_0018);
    wr(A_ST, 32'h0000_0007);
    rdc("sw7", A_ST, 32'h0000_0007);
    wr(A_CTL, 32'h0000_0080);
    chk("listen", {27'h0, listen_only, gate}, 32'h0000_0012);
    send(2'h2, LFC_NONE);
    rdc("no_tx", A_ST, 32'h0000_0007);
    $display("t_events done");
  endtask
  task automatic t_irq();
    logic [31:0] q;
    wr(A_CTL, 32'h0000_0006);
    wb(1'b0, A_ST, 32'h0000_0000, q);
    send(2'h1, LFC_NONE);
    repeat (2) @(posedge core_clk);
    chk("irq_st", {31'h0, can_irq}, 32'h1);
    wb(1'b0, A_ST, 32'h0000_0000, q);
    repeat (3) @(posedge core_clk);
    chk("irq_clr", {31'h0, can_irq}, 32'h0);
    wr(A_CTL, 32'h0000_0004);
    wr(A_ST, 32'h0000_0000);
    send(2'h1, LFC_NONE);
    chk("irq_off", {31'h0, can_irq}, 32'h0);
    rdc("upd", A_ST, 32'h0000_0010);
    wr(A_CTL, 32'h0000_000a);
    tx_error_counter <= 9'h060;
    repeat (6) @(posedge core_clk);
    chk("irq_err", {31'h0, can_irq}, 32'h1);
    rdc("cnt", A_CNT, 32'h0000_0060);
    rdc("irq_reg", A_IRQ, 32'h0000_0006);
    tx_error_counter <= 9'h000;
    repeat (6) @(posedge core_clk);
    wb(1'b0, A_ST, 32'h0000_0000, q);
    repeat (3) @(posedge core_clk);
    chk("irq_clr2", {31'h0, can_irq}, 32'h0);
    $display("t_irq done");
  endtask
  task automatic t_timers();
    logic [31:0] a;
    logic [31:0] b;
    wr(A_CTL, 32'h0000_0010);
    wb(1'b0, A_SYS, 32'h0000_0000, a);
    repeat (20) @(posedge core_clk);
    wb(1'b0, A_SYS, 32'h0000_0000, b);
    chk("sys_run", {31'h0, a != b}, 32'h1);
    wr(A_CTL, 32'h0000_0020);
    wb(1'b0, A_SYS, 32'h0000_0000, a);
    repeat (300) @(posedge core_clk);
    wb(1'b0, A_SYS, 32'h0000_0000, b);
    chk("sys_hold", b, a);
    wb(1'b0, A_DLY, 32'h0000_0000, a);
    chk("dly_us", {31'h0, a == 2 || a == 3}, 32'h1);
    wr(A_CTL, 32'h0000_0000);
    rdc("dly_off", A_DLY, 32'h0000_0000);
    $display("t_timers done");
  endtask

  initial
  begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_timing();
    t_flags();
    t_events();
    t_irq();
    t_timers();
    tally_and_finish();
  end
endmodule
